//--- design/floppy_reset_and_host_regs.sv
/*
 * host-facing front end of the floppy controller: reset handling, rate and
 * precompensation selection, drive output, tape select and status registers.
 * assumes the host port strobes and the core status come from logic on i_clk,
 * and that i_por is a power-on clear separate from the bus reset i_reset.
 */
`timescale 1ns/1ps
module floppy_reset_and_host_regs (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic       i_por,
   // host port
   input  wire logic [2:0] i_addr,
   input  wire logic       i_wr_en,
   input  wire logic       i_rd_en,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   // core status
   input  wire logic       i_core_ready,
   input  wire logic       i_core_dir,
   input  wire logic       i_core_busy,
   input  wire logic [1:0] i_core_seek,
   input  wire logic       i_specify_load,
   input  wire logic       i_specify_pio,
   // interrupt and transfer signals
   input  wire logic       i_core_irq,
   input  wire logic       i_core_drq,
   input  wire logic       i_dack_n,
   input  wire logic       i_tc,
   // drive read data pin
   input  wire logic       i_read_pulse_n,
   // outputs
   output logic            o_core_reset,
   output logic            o_irq,
   output logic            o_drq,
   output logic            o_core_dack_n,
   output logic            o_core_tc,
   output logic            o_first_motor_on,
   output logic            o_second_motor_on,
   output logic            o_drive_choice,
   output logic      [2:0] o_precomp_sel,
   output logic      [1:0] o_rate_sel,
   output logic            o_pio_mode,
   output logic            o_cell_tick,
   output logic            o_sep_clock,
   output logic            o_sep_data
);
   logic [7:0] drive_output_control_reg;
   logic [1:0] tape_select_store_reg;
   logic [2:0] precomp_reg;
   logic [1:0] rate_reg;
   logic       rate_load_reg;
   logic [3:0] sw_reset_cnt_reg;
   logic       pio_mode_reg;
   logic       func_reset;
   logic       dsr_reset_active;
   logic       wr_doc;
   logic       wr_tss;
   logic       wr_rsc;
   logic       wr_drc;
   logic       gate;
   logic [7:0] status_value;
   logic [7:0] read_value;

   rate_sep_if rs ();

   // write strobes decoded once per register
   assign wr_doc = i_wr_en && (i_addr == fdc_front_pkg::OFS_DRIVE_OUTPUT);
   assign wr_tss = i_wr_en && (i_addr == fdc_front_pkg::OFS_TAPE_SELECT);
   assign wr_rsc = i_wr_en && (i_addr == fdc_front_pkg::OFS_STATUS_RATE);
   assign wr_drc = i_wr_en && (i_addr == fdc_front_pkg::OFS_DISK_RATE);

   // drive output control: only the bus reset clears it, the function reset
   // driven from its own bit must not reset the register holding that bit
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         drive_output_control_reg <= fdc_front_pkg::DOC_RESET;
      end else if (wr_doc) begin
         drive_output_control_reg <= i_wdata & fdc_front_pkg::DOC_WRITABLE;
      end
   end

   // tape unit code is stored and read back only, nothing else looks at it
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         tape_select_store_reg <= fdc_front_pkg::TSS_RESET[1:0];
      end else if (wr_tss) begin
         tape_select_store_reg <= i_wdata[1:0] & fdc_front_pkg::TSS_MASK;
      end
   end

   // precompensation from the rate select register; kept across function reset
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         precomp_reg <= fdc_front_pkg::RSC_RESET[fdc_front_pkg::RSC_PRECOMP_LSB +: 3];
      end else if (wr_rsc) begin
         precomp_reg <= i_wdata[fdc_front_pkg::RSC_PRECOMP_LSB +: 3];
      end
   end

   // data rate follows whichever rate register was written last; a write to
   // both in one cycle cannot happen on a single address port
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rate_reg      <= fdc_front_pkg::RSC_RESET[fdc_front_pkg::RSC_RATE_LSB +: 2];
         rate_load_reg <= 1'b1;
      end else if (wr_rsc || wr_drc) begin
         rate_reg      <= i_wdata[fdc_front_pkg::RSC_RATE_LSB +: 2];
         rate_load_reg <= 1'b1;
      end else begin
         rate_load_reg <= 1'b0;
      end
   end

   // self-clearing software reset from the rate select register; a held drive
   // output reset discards it so that only the host can end that reset
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sw_reset_cnt_reg <= '0;
      end else if (func_reset) begin
         sw_reset_cnt_reg <= '0;
      end else if (wr_rsc && i_wdata[fdc_front_pkg::RSC_SW_RESET]) begin
         sw_reset_cnt_reg <= fdc_front_pkg::SW_RESET_CYCLES;
      end else if (sw_reset_cnt_reg != '0) begin
         sw_reset_cnt_reg <= sw_reset_cnt_reg - 4'h1;
      end
   end

   assign func_reset       = !drive_output_control_reg[fdc_front_pkg::DOC_FUNC_RESET_N];
   assign dsr_reset_active = (sw_reset_cnt_reg != '0);

   // core reset: the register bit holds it until the host sets it, the rate
   // select pulse ends on its own; bus reset leaves the bit at zero
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_core_reset <= 1'b1;
      end else begin
         o_core_reset <= func_reset || dsr_reset_active || (wr_rsc && i_wdata[fdc_front_pkg::RSC_SW_RESET]);
      end
   end

   // timing setup mode survives both resets; only power-on clears it
   always_ff @(posedge i_clk) begin
      if (i_por) begin
         pio_mode_reg <= 1'b0;
      end else if (i_specify_load && !o_core_reset) begin
         pio_mode_reg <= i_specify_pio;
      end
   end

   // motor and drive select outputs straight from the register bits
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_first_motor_on  <= 1'b0;
         o_second_motor_on <= 1'b0;
         o_drive_choice    <= 1'b0;
      end else begin
         o_first_motor_on  <= drive_output_control_reg[fdc_front_pkg::DOC_FIRST_MOTOR];
         o_second_motor_on <= drive_output_control_reg[fdc_front_pkg::DOC_SECOND_MOTOR];
         o_drive_choice    <= drive_output_control_reg[fdc_front_pkg::DOC_DRIVE_CHOICE];
      end
   end

   assign gate = drive_output_control_reg[fdc_front_pkg::DOC_GATE];

   // interrupt and transfer signals pass only while the gate bit is set;
   // an inactive acknowledge is high so the gated value idles high
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_irq         <= 1'b0;
         o_drq         <= 1'b0;
         o_core_dack_n <= 1'b1;
         o_core_tc     <= 1'b0;
      end else begin
         o_irq         <= gate && i_core_irq;
         o_drq         <= gate && i_core_drq;
         o_core_dack_n <= !gate || i_dack_n;
         o_core_tc     <= gate && i_tc;
      end
   end

   // rate and precompensation toward the write path
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_precomp_sel <= fdc_front_pkg::RSC_RESET[fdc_front_pkg::RSC_PRECOMP_LSB +: 3];
         o_rate_sel    <= fdc_front_pkg::RSC_RESET[fdc_front_pkg::RSC_RATE_LSB +: 2];
         o_pio_mode    <= 1'b0;
      end else begin
         o_precomp_sel <= precomp_reg;
         o_rate_sel    <= rate_reg;
         o_pio_mode    <= pio_mode_reg;
      end
   end

   // status flags; a core held in reset reports nothing but the transfer mode
   always_comb begin
      status_value = 8'h00;
      status_value[fdc_front_pkg::MSF_PIO] = pio_mode_reg;
      if (!o_core_reset) begin
         status_value[fdc_front_pkg::MSF_READY]  = i_core_ready;
         status_value[fdc_front_pkg::MSF_DIR]    = i_core_ready && i_core_dir;
         status_value[fdc_front_pkg::MSF_BUSY]   = i_core_busy;
         status_value[fdc_front_pkg::MSF_SEEK_B] = i_core_seek[1];
         status_value[fdc_front_pkg::MSF_SEEK_A] = i_core_seek[0];
      end
   end

   // read mux; the rate registers are write only: the rate select offset returns status,
   // the disk rate offset reads as zero like any unmapped offset
   always_comb begin
      read_value = 8'h00;
      unique case (i_addr)
         fdc_front_pkg::OFS_DRIVE_OUTPUT: read_value = drive_output_control_reg;
         fdc_front_pkg::OFS_TAPE_SELECT:  read_value = {6'h00, tape_select_store_reg};
         fdc_front_pkg::OFS_STATUS_RATE:  read_value = status_value;
         default:                         read_value = 8'h00;
      endcase
   end

   // read data registered one cycle after the strobe, zero otherwise
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_rd_en) begin
         o_rdata <= read_value;
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // rate towards the separator
   assign rs.rate      = rate_reg;
   assign rs.rate_load = rate_load_reg;

   data_separator u_sep (
      .i_clk          (i_clk),
      .i_reset        (i_reset),
      .i_read_pulse_n (i_read_pulse_n),
      .sep            (rs.sep)
   );

   // separator results registered once more so the top outputs stay flops
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_cell_tick <= 1'b0;
         o_sep_clock <= 1'b0;
         o_sep_data  <= 1'b0;
      end else begin
         o_cell_tick <= rs.cell_tick;
         o_sep_clock <= rs.sep_clock;
         o_sep_data  <= rs.sep_data;
      end
   end
endmodule : floppy_reset_and_host_regs

//--- design/fdc_front_pkg.sv
/*
 * constants shared by the floppy host register front end and its data separator.
 * assumes a 100 MHz device clock and byte-wide host accesses at small port offsets.
 */
// Summary of operation
// - bus reset clears core, keeps timing setup values
// - either register reset bit clears core registers
// - drive output reset outranks rate select reset
// - rate select reset self-clears; other needs host
// - write precompensation from rate select bits 4:2
// - last written rate register sets data rate
// - new data rate rescales separator clock
// - phase-locked loop separates clock from data
// - drive output register readable; bus reset clears
// - bits 5 and 4 switch drive motors
// - bit 3 gates interrupt and transfer signals
// - bit 2 low holds function reset only
// - bit 0 selects first or second drive
// - tape unit code stored, otherwise unused
// - status bit 7 shows ready for byte
// - status bit 6 shows transfer direction
// - status bit 5 shows programmed transfer mode
// - status bit 4 shows command in progress
// - status bits 1:0 show drive seeking
// - bus reset loads rate select with 02h
// - rate select bit 7 is self-clearing reset
package fdc_front_pkg;
   // host port offsets
   localparam logic [2:0] OFS_DRIVE_OUTPUT = 3'h2;
   localparam logic [2:0] OFS_TAPE_SELECT  = 3'h3;
   localparam logic [2:0] OFS_STATUS_RATE  = 3'h4;  // status on read, rate select on write
   localparam logic [2:0] OFS_DISK_RATE    = 3'h7;
   // drive output control fields
   localparam int DOC_SECOND_MOTOR = 5;
   localparam int DOC_FIRST_MOTOR  = 4;
   localparam int DOC_GATE         = 3;
   localparam int DOC_FUNC_RESET_N = 2;
   localparam int DOC_DRIVE_CHOICE = 0;
   localparam logic [7:0] DOC_WRITABLE = 8'h3D;
   localparam logic [7:0] DOC_RESET    = 8'h00;
   // rate select and tape select fields
   localparam int RSC_SW_RESET     = 7;
   localparam int RSC_PRECOMP_LSB  = 2;
   localparam int RSC_RATE_LSB     = 0;
   localparam logic [7:0] RSC_RESET = 8'h02;
   localparam logic [7:0] TSS_RESET = 8'h00;
   localparam logic [1:0] TSS_MASK  = 2'h3;
   // status fields
   localparam int MSF_READY   = 7;
   localparam int MSF_DIR     = 6;
   localparam int MSF_PIO     = 5;
   localparam int MSF_BUSY    = 4;
   localparam int MSF_SEEK_B  = 1;
   localparam int MSF_SEEK_A  = 0;
   // data rate codes and bit cell times
   localparam logic [1:0] RATE_500K = 2'h0;
   localparam logic [1:0] RATE_300K = 2'h1;
   localparam logic [1:0] RATE_250K = 2'h2;
   localparam logic [1:0] RATE_1M   = 2'h3;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CELL_NS_500K  = 2000;
   localparam int CELL_NS_300K  = 3333;
   localparam int CELL_NS_250K  = 4000;
   localparam int CELL_NS_1M    = 1000;
   localparam int CELL_W        = 9;
   localparam logic [CELL_W-1:0] CELL_CYC_500K = CELL_W'(CELL_NS_500K / CLK_PERIOD_NS);
   localparam logic [CELL_W-1:0] CELL_CYC_300K = CELL_W'(CELL_NS_300K / CLK_PERIOD_NS);
   localparam logic [CELL_W-1:0] CELL_CYC_250K = CELL_W'(CELL_NS_250K / CLK_PERIOD_NS);
   localparam logic [CELL_W-1:0] CELL_CYC_1M   = CELL_W'(CELL_NS_1M / CLK_PERIOD_NS);
   // software reset pulse held toward the core
   localparam logic [3:0] SW_RESET_CYCLES = 4'h4;

   // cycles per bit cell for a rate code
   function automatic logic [CELL_W-1:0] cell_cycles(input logic [1:0] rate);
      unique case (rate)
         RATE_500K: cell_cycles = CELL_CYC_500K;
         RATE_300K: cell_cycles = CELL_CYC_300K;
         RATE_250K: cell_cycles = CELL_CYC_250K;
         RATE_1M:   cell_cycles = CELL_CYC_1M;
      endcase
   endfunction : cell_cycles
endpackage : fdc_front_pkg

//--- design/rate_sep_if.sv
/*
 * carrier between the host register front end and the data separator.
 * assumes both ends run on the same device clock.
 */
`timescale 1ns/1ps
interface rate_sep_if;
   logic [1:0] rate;
   logic       rate_load;
   logic       cell_tick;
   logic       sep_clock;
   logic       sep_data;
   modport ctrl (output rate, output rate_load, input cell_tick, input sep_clock, input sep_data);
   modport sep  (input rate, input rate_load, output cell_tick, output sep_clock, output sep_data);
endinterface : rate_sep_if

//--- design/data_separator.sv
/*
 * digital phase-locked data separator with a rate-scaled bit cell counter.
 * assumes the raw read pulse arrives asynchronously, active low.
 */
`timescale 1ns/1ps
module data_separator (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_read_pulse_n,
   rate_sep_if.sep   sep
);
   localparam int W = fdc_front_pkg::CELL_W;
   logic          sync1_reg;
   logic          sync2_reg;
   logic          sync3_reg;
   logic          stable_reg;
   logic          pulse;
   logic [W-1:0]  cell_len_reg;
   logic [W-1:0]  phase_reg;
   logic [W-1:0]  half;
   logic [W-1:0]  quarter;

   // three-stage synchroniser, a level counts once stages two and three agree
   always_ff @(posedge i_clk) begin
      sync1_reg <= i_read_pulse_n;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (i_reset) begin
         stable_reg <= 1'b1;
      end else if (sync2_reg == sync3_reg) begin
         stable_reg <= sync3_reg;
      end
   end
   assign pulse   = (sync2_reg == sync3_reg) && !sync3_reg && stable_reg;
   assign half    = cell_len_reg >> 1;
   assign quarter = cell_len_reg >> 2;

   // cell length follows the selected rate
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cell_len_reg <= fdc_front_pkg::CELL_CYC_250K;
      end else if (sep.rate_load) begin
         cell_len_reg <= fdc_front_pkg::cell_cycles(sep.rate);
      end
   end

   // phase counter nudged toward the centre of the window each pulse falls in
   always_ff @(posedge i_clk) begin
      if (i_reset || sep.rate_load) begin
         phase_reg <= '0;
      end else if (phase_reg >= cell_len_reg - W'(1)) begin
         phase_reg <= '0;
      end else if (pulse && (phase_reg < quarter || (phase_reg >= half && phase_reg < half + quarter))) begin
         phase_reg <= phase_reg + W'(2); // early pulse, pull phase forward
      end else if (pulse) begin
         phase_reg <= phase_reg;         // late pulse, hold back one cycle
      end else begin
         phase_reg <= phase_reg + W'(1);
      end
   end

   // clock window is the first half of the cell, data window the second
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sep.cell_tick <= 1'b0;
         sep.sep_clock <= 1'b0;
         sep.sep_data  <= 1'b0;
      end else begin
         sep.cell_tick <= (phase_reg == '0);
         sep.sep_clock <= pulse && (phase_reg < half);
         sep.sep_data  <= pulse && (phase_reg >= half);
      end
   end
endmodule : data_separator

//--- sim/floppy_front_checker.sv
/* port assertions for the floppy host front end, bound onto its top module.
   assumes one clock and a synchronous active-high bus reset. */
`timescale 1ns/1ps
module floppy_front_checker (
   input wire logic       i_clk,
   input wire logic       i_reset,
   input wire logic [2:0] i_addr,
   input wire logic       i_wr_en,
   input wire logic       i_rd_en,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic       i_core_ready,
   input wire logic       i_core_dir,
   input wire logic       i_core_busy,
   input wire logic [1:0] i_core_seek,
   input wire logic       i_core_irq,
   input wire logic       i_dack_n,
   input wire logic       o_core_reset,
   input wire logic       o_irq,
   input wire logic       o_core_dack_n,
   input wire logic       o_first_motor_on,
   input wire logic       o_second_motor_on,
   input wire logic       o_drive_choice,
   input wire logic [2:0] o_precomp_sel,
   input wire logic [1:0] o_rate_sel
);
   logic [7:0] doc_shadow_reg;
   // host view of the drive output bits; reserved ones never stick
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         doc_shadow_reg <= 8'h00;
      end else if (i_wr_en && i_addr == 3'h2) begin
         doc_shadow_reg <= i_wdata & 8'h3D;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // self-clearing reset request while the drive output bit lets the core run
   sequence seq_soft_req;
      i_wr_en && i_addr == 3'h4 && i_wdata[7] && doc_shadow_reg[2];
   endsequence
   // core held a few cycles, then freed with no host action
   sequence seq_soft_hold;
      o_core_reset [*4] ##[1:3] !o_core_reset;
   endsequence
   chk_reset_defaults: assert property (
      $past(i_reset) |-> o_core_reset && o_rate_sel == 2'h2 && o_precomp_sel == 3'h0)
      else $error("bad state after bus reset");
   chk_rdata_idle: assert property (
      !$past(i_rd_en) |-> o_rdata == 8'h00) else $error("read data not idle");
   chk_doc_readback: assert property (
      i_rd_en && i_addr == 3'h2 |=> o_rdata == $past(doc_shadow_reg)) else $error("drive output readback");
   chk_status_live: assert property (
      i_rd_en && i_addr == 3'h4 && !o_core_reset |=> o_rdata[7] == $past(i_core_ready)
      && o_rdata[6] == $past(i_core_ready && i_core_dir)
      && o_rdata[4:0] == {$past(i_core_busy), 2'h0, $past(i_core_seek)}) else $error("status flags");
   chk_status_held: assert property (
      i_rd_en && i_addr == 3'h4 && o_core_reset |=> (o_rdata & 8'hDF) == 8'h00) else $error("status in reset");
   chk_drive_outputs: assert property (
      {o_second_motor_on, o_first_motor_on, o_drive_choice} == $past({doc_shadow_reg[5:4], doc_shadow_reg[0]}))
      else $error("motor or drive choice");
   chk_func_reset: assert property (
      !$past(doc_shadow_reg[2]) |-> o_core_reset) else $error("core not held in reset");
   chk_soft_pulse: assert property (
      seq_soft_req |=> seq_soft_hold) else $error("software reset pulse");
   chk_rate_follow: assert property (
      i_wr_en && (i_addr == 3'h4 || i_addr == 3'h7) |-> ##2 o_rate_sel == $past(i_wdata[1:0], 2))
      else $error("rate not taken");
   chk_precomp_follow: assert property (
      i_wr_en && i_addr == 3'h4 |-> ##2 o_precomp_sel == $past(i_wdata[4:2], 2)) else $error("precomp not taken");
   chk_gate_irq: assert property (
      o_irq |-> $past(i_core_irq) && ($past(doc_shadow_reg[3]) || $past(doc_shadow_reg[3], 2)))
      else $error("irq passed while gated");
   chk_gate_dack: assert property (
      !o_core_dack_n |-> !$past(i_dack_n)) else $error("acknowledge without cause");
endmodule : floppy_front_checker

bind floppy_reset_and_host_regs floppy_front_checker chk_u (
   .i_clk, .i_reset, .i_addr, .i_wr_en, .i_rd_en, .i_wdata, .o_rdata, .i_core_ready, .i_core_dir,
   .i_core_busy, .i_core_seek, .i_core_irq, .i_dack_n, .o_core_reset, .o_irq, .o_core_dack_n,
   .o_first_motor_on, .o_second_motor_on, .o_drive_choice, .o_precomp_sel, .o_rate_sel);

//--- sim/host_bus_model.sv
/* host processor model: single byte reads and writes on the front end port.
   assumes each task is entered just after a rising edge. */
`timescale 1ns/1ps
module host_bus_model (
   input  wire logic       i_clk,
   output logic      [2:0] o_addr,
   output logic            o_wr_en,
   output logic            o_rd_en,
   output logic      [7:0] o_wdata
);
   initial begin
      o_addr = 3'h0;
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_wdata = 8'h00;
   end
   // strobe held for one taking edge; a gap cycle keeps strobes from re-rising in one step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      o_addr = a;
      o_wdata = d;
      o_wr_en = 1'b1;
      @(posedge i_clk);
      #1 o_wr_en = 1'b0;
      o_wdata = ~d;
      @(posedge i_clk);
      #1;
   endtask : wr
   // read strobe; the data comes back on the following edge
   task automatic rd(input logic [2:0] a);
      o_addr = a;
      o_rd_en = 1'b1;
      @(posedge i_clk);
      #1 o_rd_en = 1'b0;
      @(posedge i_clk);
      #1;
   endtask : rd
endmodule : host_bus_model

//--- sim/test_floppy_reset_and_host_regs.sv
/* self-checking bench for the floppy host front end: host model, queued read notes.
   assumes the checker file binds itself onto the design. */
`timescale 1ns/1ps
module test_floppy_reset_and_host_regs;
   logic       clk = 1'b0, rst = 1'b1, por = 1'b1, wr_en, rd_en, rd_d = 1'b0;
   logic       rdy = 1'b0, dir = 1'b0, busy = 1'b0, spec_ld = 1'b0, spec_pio = 1'b0;
   logic       irq_v = 1'b0, pulse_n = 1'b1, hit;
   logic       core_rst, irq, drq, dack_n, tc, mot_a, mot_b, choice, tick, sclk, sdat, pio;
   logic [1:0] seek = 2'h0, rate;
   logic [2:0] addr, precomp;
   logic [7:0] wdata, rdata, v;
   logic [7:0] exp_q[$];
   int         n_mismatch = 0, n_checks = 0, seed = 32'h72A9CA02;
   always #5 clk = ~clk;
   host_bus_model host_u (.i_clk(clk), .o_addr(addr), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_wdata(wdata));
   floppy_reset_and_host_regs dut_u (
      .i_clk(clk), .i_reset(rst), .i_por(por), .i_addr(addr), .i_wr_en(wr_en), .i_rd_en(rd_en),
      .i_wdata(wdata), .o_rdata(rdata), .i_core_ready(rdy), .i_core_dir(dir), .i_core_busy(busy),
      .i_core_seek(seek), .i_specify_load(spec_ld), .i_specify_pio(spec_pio), .i_core_irq(irq_v),
      .i_core_drq(irq_v), .i_dack_n(~irq_v), .i_tc(irq_v), .i_read_pulse_n(pulse_n),
      .o_core_reset(core_rst), .o_irq(irq), .o_drq(drq), .o_core_dack_n(dack_n), .o_core_tc(tc),
      .o_first_motor_on(mot_a), .o_second_motor_on(mot_b), .o_drive_choice(choice),
      .o_precomp_sel(precomp), .o_rate_sel(rate), .o_pio_mode(pio), .o_cell_tick(tick),
      .o_sep_clock(sclk), .o_sep_data(sdat));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   // note the expected byte, then let the host model read it
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host_u.rd(a);
   endtask : rd
   // bit cell length after a rate load, counted between two ticks
   task automatic period(input logic [1:0] r, input logic [15:0] e);
      int n;
      host_u.wr(3'h7, {6'h00, r});
      // the first tick of the new rate shows two edges after the write returns; an older tick may come before it
      cyc(2);
      for (n = 0; tick !== 1'b1 && n < 1000; n++) cyc(1);
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (tick !== 1'b1 && n < 1000);
      chk("cell", 16'(n), e);
      if (n >= 1000) wrap_up();
   endtask : period
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // read data lands one edge after the strobe; pair it with the oldest note
   always @(posedge clk) begin
      rd_d <= rd_en;
      if (rd_d && exp_q.size() == 0) chk("queue", 16'h1, 16'h0);
      else if (rd_d) chk("rdata", rdata, exp_q.pop_front());
   end
   // hang guard, far above the cycles a normal run takes
   initial begin
      #900000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      cyc(8);
      rst = 1'b0;
      por = 1'b0;
      cyc(1);
      chk("reset", {core_rst, rate, precomp}, 6'h30);
      {spec_pio, spec_ld, rdy, busy, seek} = 6'h3F;
      cyc(1);
      spec_ld = 1'b0;
      rd(3'h4, 8'h00);
      rd(3'h2, 8'h00);
      rd(3'h3, 8'h00);
      host_u.wr(3'h2, 8'h04);
      chk("core_rst", core_rst, 1'b0);
      spec_ld = 1'b1;
      cyc(1);
      spec_ld = 1'b0;
      cyc(1);
      chk("pio", pio, 1'b1);
      // random drive output values; bit 2 stays high so the core keeps running
      repeat (4) begin
         v = 8'($random(seed)) | 8'h04;
         host_u.wr(3'h2, v);
         chk("drive", {mot_b, mot_a, choice}, {v[5:4], v[0]});
         rd(3'h2, v & 8'h3D);
      end
      repeat (4) begin
         {rdy, dir, busy, seek} = 5'($random(seed));
         cyc(1);
         rd(3'h4, {rdy, rdy & dir, 1'b1, busy, 2'h0, seek});
      end
      host_u.wr(3'h2, 8'h04);
      irq_v = 1'b1;
      cyc(2);
      chk("gate_off", {irq, drq, tc, dack_n}, 4'h1);
      host_u.wr(3'h2, 8'h0C);
      cyc(1);
      chk("gate_on", {irq, drq, tc, dack_n}, 4'hE);
      irq_v = 1'b0;
      v = 8'($random(seed));
      host_u.wr(3'h3, v);
      rd(3'h3, {6'h00, v[1:0]});
      chk("drive", {mot_b, mot_a, choice}, 3'h0);
      // each rate code through both rate registers, the later write winning
      for (int k = 0; k < 4; k++) begin
         host_u.wr(3'h4, 8'(k * 5));
         chk("rate", {precomp, rate}, {3'(k), 2'(k)});
         host_u.wr(3'h7, 8'(3 - k));
         chk("rate", {precomp, rate}, {3'(k), 2'(3 - k)});
      end
      host_u.wr(3'h4, 8'h1E);
      chk("rate", {precomp, rate}, 5'h1E);
      host_u.wr(3'h5, 8'hFF);
      rd(3'h7, 8'h00);
      rd(3'h5, 8'h00);
      rd(3'h2, 8'h0C);
      host_u.wr(3'h4, 8'h83);
      chk("core_rst", {core_rst, rate}, 3'h7);
      cyc(5);
      chk("core_rst", core_rst, 1'b0);
      rd(3'h2, 8'h0C);
      // rate select reset raised while the drive output bit already holds the core
      host_u.wr(3'h2, 8'h08);
      host_u.wr(3'h4, 8'h83);
      host_u.wr(3'h2, 8'h0C);
      chk("core_rst", core_rst, 1'b0);
      cyc(6);
      chk("core_rst", core_rst, 1'b0);
      // a two-cycle low gets through once stages two and three agree
      pulse_n = 1'b0;
      cyc(2);
      pulse_n = 1'b1;
      hit = 1'b0;
      repeat (12) begin
         cyc(1);
         if (sclk === 1'b1 || sdat === 1'b1) hit = 1'b1;
      end
      chk("sep", hit, 1'b1);
      period(2'h3, 16'(fdc_front_pkg::CELL_CYC_1M));
      period(2'h1, 16'(fdc_front_pkg::CELL_CYC_300K));
      // bus reset in mid-run keeps the transfer mode only
      host_u.wr(3'h3, 8'h02);
      rst = 1'b1;
      cyc(4);
      rst = 1'b0;
      cyc(1);
      chk("reset", {core_rst, rate, precomp}, 6'h30);
      rd(3'h2, 8'h00);
      rd(3'h3, 8'h00);
      rd(3'h4, 8'h20);
      wrap_up();
   end
endmodule : test_floppy_reset_and_host_regs
